/* File: core/irq_flags_pkg.sv */
// Purpose: shared constants for the peripheral interrupt enable and flag block
// Assumes: 8-bit registers, one word each on a 32-bit apb bus
// Notes:   printed offsets are register indices, byte address is four times the index
package irq_flags_pkg;

  // bus geometry
  localparam int          ADDR_W            = 12;       // byte address width
  localparam int          REG_W             = 8;        // register width
  localparam int          IDX_W             = 10;       // index width, paddr[11:2]

  // register indices (byte address = index * 4)
  localparam logic [9:0]  IDX_CTRL_BANK0    = 10'h00b;  // core control, mirror bank 0
  localparam logic [9:0]  IDX_CTRL_BANK1    = 10'h08b;  // core control, mirror bank 1
  localparam logic [9:0]  IDX_CTRL_BANK2    = 10'h10b;  // core control, home address
  localparam logic [9:0]  IDX_CTRL_BANK3    = 10'h18b;  // core control, mirror bank 3
  localparam logic [9:0]  IDX_PFLAGS_ONE    = 10'h00c;  // peripheral flags, first group
  localparam logic [9:0]  IDX_PFLAGS_TWO    = 10'h00d;  // peripheral flags, second group
  localparam logic [9:0]  IDX_PEN_ONE       = 10'h08c;  // peripheral enables, first group
  localparam logic [9:0]  IDX_PEN_TWO       = 10'h08d;  // peripheral enables, second group

  // core control field positions
  localparam int          GLOBAL_EN_BIT     = 7;
  localparam int          GROUP_EN_BIT      = 6;
  localparam int          MAIN_TMR_EN_BIT   = 5;
  localparam int          EXT_PIN_EN_BIT    = 4;
  localparam int          PORT_CHG_EN_BIT   = 3;
  localparam int          MAIN_TMR_FLAG_BIT = 2;
  localparam int          EXT_PIN_FLAG_BIT  = 1;
  localparam int          PORT_CHG_FLAG_BIT = 0;

  // first peripheral group field positions (flags and enables alike)
  localparam int          CONV_BIT          = 6;
  localparam int          SERIAL_BIT        = 3;
  localparam int          CAPCOMP_BIT       = 2;
  localparam int          PERIOD_BIT        = 1;
  localparam int          AUX_TMR_BIT       = 0;

  // second peripheral group field position
  localparam int          NV_WRITE_BIT      = 4;

  // implemented-bit masks
  localparam logic [7:0]  MASK_GROUP_ONE    = 8'h4f;
  localparam logic [7:0]  MASK_GROUP_TWO    = 8'h10;

  // reset values
  localparam logic [7:0]  RST_CTRL          = 8'h00;
  localparam logic [7:0]  RST_GROUP         = 8'h00;
  localparam logic [31:0] RDATA_IDLE        = 32'h0000_0000;

endpackage : irq_flags_pkg

/* File: core/sticky_flag_bank.sv */
// Purpose: bank of sticky event flags, software writable, events set
// Assumes: events come from logic on the same clock, no synchroniser needed
// Notes:   an event in the cycle of a software write wins over the written zero
module sticky_flag_bank #(
  parameter int         WIDTH    = 8,
  parameter logic [7:0] IMPL     = 8'hff,    // implemented bits, others read zero
  parameter logic [7:0] RST_VAL  = 8'h00
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // software write port
  input  wire logic             wr_en,       // one-cycle write strobe
  input  wire logic [WIDTH-1:0] wr_data,     // value written
  // hardware event port
  input  wire logic [WIDTH-1:0] set_evt,     // set requests, level or pulse
  // state
  output logic      [WIDTH-1:0] flags_ff     // registered flags
);

  logic [WIDTH-1:0] nxt_flags;               // next flag values

  // per bit: keep, take written value, then or in the event
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      if (!IMPL[b]) begin
        nxt_flags[b] = 1'b0;                 // unimplemented bit stays zero
      end else if (wr_en) begin
        nxt_flags[b] = wr_data[b] | set_evt[b];
      end else begin
        nxt_flags[b] = flags_ff[b] | set_evt[b];
      end
    end
  end

  // register only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= RST_VAL[WIDTH-1:0];
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule : sticky_flag_bank

/* File: core/periph_irq_ctrl.sv */
// Purpose: interrupt enables, flags and combined core request behind an apb slave
// Assumes: event inputs are driven by logic on pclk; apb master per amba rules
// Notes:   no wait state on any transfer; read data is registered in setup
module periph_irq_ctrl
  import irq_flags_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // peripheral group one events
  input  wire logic              converter_done,
  input  wire logic              serial_port_event,
  input  wire logic              capcomp_event,
  input  wire logic              period_match_event,
  input  wire logic              aux_timer_overflow,
  // peripheral group two events
  input  wire logic              nv_write_done,
  // core-level events
  input  wire logic              main_timer_overflow,
  input  wire logic              external_pin_edge,
  input  wire logic              port_change_event,
  // request to the core
  output logic                   irq_request
);

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic [IDX_W-1:0] idx;           // register index from the byte address
  logic             aligned;       // low address bits are zero
  logic             hit_ctrl;      // any mirror of the core control register
  logic             hit_pf1;       // peripheral flags one
  logic             hit_pf2;       // peripheral flags two
  logic             hit_pe1;       // peripheral enables one
  logic             hit_pe2;       // peripheral enables two
  logic             hit_any;       // mapped location
  logic             setup_ph;      // first cycle of a transfer
  logic             access_ph;     // completing cycle of a transfer
  logic             wr_commit;     // write takes effect on this edge

  assign idx       = paddr[ADDR_W-1:2];
  assign aligned   = (paddr[1:0] == 2'b00);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;

  // all four bank mirrors land on one physical register
  assign hit_ctrl  = aligned & ((idx == IDX_CTRL_BANK0) | (idx == IDX_CTRL_BANK1) |
                                (idx == IDX_CTRL_BANK2) | (idx == IDX_CTRL_BANK3));
  assign hit_pf1   = aligned & (idx == IDX_PFLAGS_ONE);
  assign hit_pf2   = aligned & (idx == IDX_PFLAGS_TWO);
  assign hit_pe1   = aligned & (idx == IDX_PEN_ONE);
  assign hit_pe2   = aligned & (idx == IDX_PEN_TWO);
  assign hit_any   = hit_ctrl | hit_pf1 | hit_pf2 | hit_pe1 | hit_pe2;

  // write commits only at the access edge and only to a mapped word
  assign wr_commit = access_ph & pwrite & hit_any;

  // handshake is combinational: ready in every access cycle, so no wait states
  assign pready    = access_ph;

  // ---------------------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------------------
  logic [REG_W-1:0] ctrl_en_ff;    // core control enable bits (7..3)
  logic [REG_W-1:0] nxt_ctrl_en;
  logic [REG_W-1:0] pen_one_ff;    // peripheral enables one
  logic [REG_W-1:0] nxt_pen_one;
  logic [REG_W-1:0] pen_two_ff;    // peripheral enables two
  logic [REG_W-1:0] nxt_pen_two;
  logic [REG_W-1:0] ctrl_en_mask;  // enable half of the control register

  assign ctrl_en_mask = 8'hf8;

  // next enable values; unimplemented bits are masked so writes there vanish
  always_comb begin
    nxt_ctrl_en = ctrl_en_ff;
    nxt_pen_one = pen_one_ff;
    nxt_pen_two = pen_two_ff;
    if (wr_commit && hit_ctrl) begin
      nxt_ctrl_en = pwdata[REG_W-1:0] & ctrl_en_mask;
    end
    if (wr_commit && hit_pe1) begin
      nxt_pen_one = pwdata[REG_W-1:0] & MASK_GROUP_ONE;
    end
    if (wr_commit && hit_pe2) begin
      nxt_pen_two = pwdata[REG_W-1:0] & MASK_GROUP_TWO;
    end
  end

  // register only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= RST_CTRL;
      pen_one_ff <= RST_GROUP;
      pen_two_ff <= RST_GROUP;
    end else begin
      ctrl_en_ff <= nxt_ctrl_en;
      pen_one_ff <= nxt_pen_one;
      pen_two_ff <= nxt_pen_two;
    end
  end

  // ---------------------------------------------------------------------------
  // flag banks
  // ---------------------------------------------------------------------------
  logic [REG_W-1:0] pf1_evt;       // group one events in register layout
  logic [REG_W-1:0] pf2_evt;       // group two events in register layout
  logic [REG_W-1:0] core_evt;      // core-level events in register layout
  logic [REG_W-1:0] pf1_ff;        // group one flags
  logic [REG_W-1:0] pf2_ff;        // group two flags
  logic [REG_W-1:0] core_flag_ff;  // core-level flags (bits 2..0)

  // events land on their flag bit no matter what any enable says
  always_comb begin
    pf1_evt                    = 8'h00;
    pf1_evt[CONV_BIT]          = converter_done;
    pf1_evt[SERIAL_BIT]        = serial_port_event;
    pf1_evt[CAPCOMP_BIT]       = capcomp_event;
    pf1_evt[PERIOD_BIT]        = period_match_event;
    pf1_evt[AUX_TMR_BIT]       = aux_timer_overflow;
    pf2_evt                    = 8'h00;
    pf2_evt[NV_WRITE_BIT]      = nv_write_done;
    core_evt                   = 8'h00;
    core_evt[MAIN_TMR_FLAG_BIT] = main_timer_overflow;
    core_evt[EXT_PIN_FLAG_BIT]  = external_pin_edge;
    core_evt[PORT_CHG_FLAG_BIT] = port_change_event;
  end

  // group one flags: software may write either value, zero clears
  sticky_flag_bank #(
    .WIDTH   (REG_W),
    .IMPL    (MASK_GROUP_ONE),
    .RST_VAL (RST_GROUP)
  ) u_pf1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_commit & hit_pf1),
    .wr_data  (pwdata[REG_W-1:0]),
    .set_evt  (pf1_evt),
    .flags_ff (pf1_ff)
  );

  // group two flags: only the nv write bit exists
  sticky_flag_bank #(
    .WIDTH   (REG_W),
    .IMPL    (MASK_GROUP_TWO),
    .RST_VAL (RST_GROUP)
  ) u_pf2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_commit & hit_pf2),
    .wr_data  (pwdata[REG_W-1:0]),
    .set_evt  (pf2_evt),
    .flags_ff (pf2_ff)
  );

  // core-level flags share the control word with the enables
  sticky_flag_bank #(
    .WIDTH   (REG_W),
    .IMPL    (8'h07),
    .RST_VAL (RST_CTRL)
  ) u_core (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_commit & hit_ctrl),
    .wr_data  (pwdata[REG_W-1:0]),
    .set_evt  (core_evt),
    .flags_ff (core_flag_ff)
  );

  // ---------------------------------------------------------------------------
  // combined request
  // ---------------------------------------------------------------------------
  logic [REG_W-1:0] ctrl_word;     // full control register as read back
  logic             core_pend;     // a core-level source is flagged and enabled
  logic             per_pend;      // a peripheral source is flagged and enabled
  logic             irq_ff;        // registered request
  logic             nxt_irq;

  assign ctrl_word = ctrl_en_ff | core_flag_ff;

  // pair each core enable with its flag
  assign core_pend = (ctrl_en_ff[MAIN_TMR_EN_BIT] & core_flag_ff[MAIN_TMR_FLAG_BIT]) |
                     (ctrl_en_ff[EXT_PIN_EN_BIT]  & core_flag_ff[EXT_PIN_FLAG_BIT])  |
                     (ctrl_en_ff[PORT_CHG_EN_BIT] & core_flag_ff[PORT_CHG_FLAG_BIT]);

  // same bit positions for flag and enable, so an or-reduce of flag and enable per group suffices
  assign per_pend  = |(pf1_ff & pen_one_ff) | |(pf2_ff & pen_two_ff);

  // peripheral sources also need the group gate; everything needs global
  always_comb begin
    nxt_irq = ctrl_en_ff[GLOBAL_EN_BIT] &
              (core_pend | (ctrl_en_ff[GROUP_EN_BIT] & per_pend));
  end

  // register only; request lags its cause by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_request = irq_ff;

  // ---------------------------------------------------------------------------
  // read path, captured in the setup cycle
  // ---------------------------------------------------------------------------
  logic [31:0] rdata_ff;           // registered read data
  logic [31:0] nxt_rdata;
  logic        err_ff;             // registered error answer
  logic        nxt_err;
  logic [7:0]  rd_byte;            // selected register

  // select; flags read live, unmapped words read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = ctrl_word;
    end else if (hit_pf1) begin
      rd_byte = pf1_ff;
    end else if (hit_pf2) begin
      rd_byte = pf2_ff;
    end else if (hit_pe1) begin
      rd_byte = pen_one_ff;
    end else if (hit_pe2) begin
      rd_byte = pen_two_ff;
    end
  end

  // load in setup, hold through the access phase
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    if (setup_ph) begin
      nxt_rdata = {24'h00_0000, rd_byte} & {32{~pwrite}};
      nxt_err   = ~hit_any;
    end
  end

  // register only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= RDATA_IDLE;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // error is only shown while ready is high, as apb expects
  assign prdata  = rdata_ff;
  assign pslverr = err_ff & access_ph;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_group_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_en_ff[GROUP_EN_BIT] && !core_pend) |=> !irq_request)
    else $error("peripheral request passed a closed group gate");

  chk_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    converter_done |=> pf1_ff[CONV_BIT])
    else $error("converter event did not set its flag");

  chk_nv_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    nv_write_done |=> pf2_ff[NV_WRITE_BIT])
    else $error("nv write event did not set its flag");

  chk_serial_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_en_ff[GLOBAL_EN_BIT] && ctrl_en_ff[GROUP_EN_BIT] &&
     pen_one_ff[SERIAL_BIT] && pf1_ff[SERIAL_BIT]) |=> irq_request)
    else $error("enabled serial flag raised no request");

  chk_capcomp_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_en_ff[GLOBAL_EN_BIT] && ctrl_en_ff[GROUP_EN_BIT] &&
     pen_one_ff[CAPCOMP_BIT] && pf1_ff[CAPCOMP_BIT]) |=> irq_request)
    else $error("enabled capture/compare flag raised no request");

  chk_period_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_en_ff[GLOBAL_EN_BIT] && ctrl_en_ff[GROUP_EN_BIT] &&
     pen_one_ff[PERIOD_BIT] && pf1_ff[PERIOD_BIT]) |=> irq_request)
    else $error("enabled period match flag raised no request");

  chk_aux_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_en_ff[GLOBAL_EN_BIT] && ctrl_en_ff[GROUP_EN_BIT] &&
     pen_one_ff[AUX_TMR_BIT] && pf1_ff[AUX_TMR_BIT]) |=> irq_request)
    else $error("enabled aux overflow flag raised no request");

  chk_pen_two_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && hit_pe2) |=> (pen_two_ff == ($past(pwdata[7:0]) & MASK_GROUP_TWO)))
    else $error("enables two holds a bit other than nv write");

  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ((pen_one_ff & ~MASK_GROUP_ONE) == 8'h00) && ((pf1_ff & ~MASK_GROUP_ONE) == 8'h00))
    else $error("unimplemented bit reads as one");

  chk_mirror_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && hit_ctrl) |=> (ctrl_en_ff == ($past(pwdata[7:0]) & 8'hf8)))
    else $error("mirrored control write missed the register");

  chk_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_en_ff[GLOBAL_EN_BIT] [*2] |-> !irq_request)
    else $error("request raised with global enable clear");

  chk_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (pf1_ff[SERIAL_BIT] && !(wr_commit && hit_pf1)) |=> pf1_ff[SERIAL_BIT])
    else $error("flag dropped without a software write");

  chk_read_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !hit_any) ##1 access_ph |-> (prdata == 32'h0000_0000) && pslverr)
    else $error("unmapped read did not answer zero with error");

endmodule : periph_irq_ctrl

/* File: sim/irq_source_model.sv */
// Purpose: stand-in for the peripheral and core event sources of the interrupt block
// Assumes: sources share pclk with the block, so events need no synchroniser
// Notes:   each requested event becomes a one-cycle pulse, the shortest the block must catch
module irq_source_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request from the bench, one bit per source
  input  wire logic [8:0] fire,
  // event lines toward the block
  output logic      [8:0] evt_ff
);
  timeunit 1ns;
  timeprecision 1ns;

  // register the request so every event leaves right after an edge, as real sources do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= 9'h000;
    end else begin
      evt_ff <= fire;
    end
  end
endmodule : irq_source_model

/* File: sim/tb_peripheral_interrupt_enable_flags.sv */
// Purpose: self-checking bench for the peripheral interrupt enable and flag block
// Assumes: no wait state on any apb transfer, but the master waits for pready anyway
// Notes:   event bits: 0 aux, 1 period, 2 capcomp, 3 serial, 4 conv, 5 nv, 6 port, 7 ext, 8 main
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_peripheral_interrupt_enable_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_flags_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [8:0]  fire, evt, fv;
  logic [7:0]  ctl, e1, e2;
  logic        last_err;
  logic [31:0] seed;
  int          failures, checked;
  logic [9:0]  idx_tab [5] = '{IDX_CTRL_BANK0, IDX_PFLAGS_ONE, IDX_PFLAGS_TWO, IDX_PEN_ONE,
                                IDX_PEN_TWO};
  logic [7:0]  msk_tab [5] = '{8'hff, MASK_GROUP_ONE, MASK_GROUP_TWO, MASK_GROUP_ONE,
                                MASK_GROUP_TWO};

  periph_irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_timer_overflow(evt[0]), .period_match_event(evt[1]),
    .capcomp_event(evt[2]), .serial_port_event(evt[3]), .converter_done(evt[4]),
    .nv_write_done(evt[5]), .port_change_event(evt[6]), .external_pin_edge(evt[7]),
    .main_timer_overflow(evt[8]), .irq_request(irq_request));
  irq_source_model src (.pclk(pclk), .presetn(presetn), .fire(fire), .evt_ff(evt));

  // expected register images, worked out from the event vector alone
  function automatic logic [7:0] f1_of(input logic [8:0] v);
    return {1'b0, v[4], 2'b00, v[3:0]};
  endfunction : f1_of
  function automatic logic [7:0] f2_of(input logic [8:0] v);
    return {3'b000, v[5], 4'h0};
  endfunction : f2_of
  function automatic logic irq_exp(input logic [7:0] c, f1, f2, n1, n2);
    return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & |((f1 & n1) | (f2 & n2))));
  endfunction : irq_exp
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  // one apb transfer; an idle cycle before setup keeps every strobe to one change per step
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdv      = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic fire_evt(input logic [8:0] v);
    @(posedge pclk);
    fire <= v;
    @(posedge pclk);
    fire <= 9'h000;
    repeat (4) @(posedge pclk);
  endtask : fire_evt

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fire = 9'h000;
    seed = 32'h0000_a50c;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and the unmapped places
    foreach (idx_tab[i]) begin
      apb(1'b0, idx_tab[i], 8'h00);
      `CHK("reset value", 32'h0000_0000, rdv)
    end
    apb(1'b0, 10'h001, 8'h00);
    `CHK("unmapped read", 32'h0000_0000, rdv)
    `CHK("unmapped error", 1'b1, last_err)
    wr(10'h001, 8'hff);
    `CHK("unmapped write error", 1'b1, last_err)
    apb(1'b0, 10'h001, 8'h00);
    `CHK("unmapped write ignored", 32'h0000_0000, rdv)
    $display("test reset done");
    // writable bits only, everything else reads zero
    foreach (idx_tab[i]) begin
      seed = lfsr(seed);
      wr(idx_tab[i], seed[7:0]);
      apb(1'b0, idx_tab[i], 8'h00);
      `CHK("masked readback", {24'h00_0000, seed[7:0] & msk_tab[i]}, rdv)
      `CHK("mapped error", 1'b0, last_err)
    end
    // one control register behind every bank address
    wr(IDX_CTRL_BANK1, 8'h5a);
    foreach (idx_tab[i]) begin
      apb(1'b0, IDX_CTRL_BANK0 + 10'(i[1:0]) * 10'h080, 8'h00);
      if (i < 4) `CHK("mirror", 32'h0000_005a, rdv)
    end
    $display("test registers done");
    // each source alone: gated by its own enable, peripheral sources also by the group bit
    for (int s = 0; s < 9; s++) begin
      fv = 9'h001 << s;
      wr(IDX_CTRL_BANK0, 8'h00);
      wr(IDX_PFLAGS_ONE, 8'h00);
      wr(IDX_PFLAGS_TWO, 8'h00);
      wr(IDX_PEN_ONE, f1_of(fv));
      wr(IDX_PEN_TWO, f2_of(fv));
      ctl = (s < 6) ? 8'hc0 : (8'h80 | (8'h01 << (s - 3)));
      wr(IDX_CTRL_BANK2, ctl);
      fire_evt(~fv & 9'h1ff);
      `CHK("other sources", 1'b0, irq_request)
      fire_evt(fv);
      `CHK("own source", 1'b1, irq_request)
      if (s < 6) begin
        wr(IDX_CTRL_BANK2, 8'h80);
        repeat (2) @(posedge pclk);
        `CHK("group off", 1'b0, irq_request)
        wr(IDX_CTRL_BANK3, 8'hc0);
        repeat (2) @(posedge pclk);
        `CHK("flag held", 1'b1, irq_request)
        wr(IDX_PFLAGS_ONE, 8'h00);
        wr(IDX_PFLAGS_TWO, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("flag cleared", 1'b0, irq_request)
      end
    end
    $display("test sources done");
    // random enables and events against the model of the request
    for (int k = 0; k < 30; k++) begin
      seed = lfsr(seed);
      wr(IDX_CTRL_BANK0, 8'h00);
      wr(IDX_PFLAGS_ONE, 8'h00);
      wr(IDX_PFLAGS_TWO, 8'h00);
      e1 = seed[7:0] & MASK_GROUP_ONE;
      e2 = seed[15:8] & MASK_GROUP_TWO;
      wr(IDX_PEN_ONE, seed[7:0]);
      wr(IDX_PEN_TWO, seed[15:8]);
      ctl = {seed[23:19], 3'b000};
      wr(IDX_CTRL_BANK3, ctl);
      fv = seed[31:23];
      fire_evt(fv);
      apb(1'b0, IDX_PFLAGS_ONE, 8'h00);
      `CHK("flags one", {24'h00_0000, f1_of(fv)}, rdv)
      apb(1'b0, IDX_PFLAGS_TWO, 8'h00);
      `CHK("flags two", {24'h00_0000, f2_of(fv)}, rdv)
      ctl = ctl | {5'b00000, fv[8:6]};
      apb(1'b0, IDX_CTRL_BANK2, 8'h00);
      `CHK("core control", {24'h00_0000, ctl}, rdv)
      `CHK("request", irq_exp(ctl, f1_of(fv), f2_of(fv), e1, e2), irq_request)
    end
    $display("test random done");
    report_and_stop();
  end
endmodule : tb_peripheral_interrupt_enable_flags
